// [smc_matrix_cfg.sv]
`timescale 1ns/1ps
module smc_matrix_cfg
  import smc_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = SMC_CYCLES_PER_US
) (
  input  wire logic                      clock_in,
  input  wire logic                      rst_b_in,
  // register port from the serial frame decoder, same clock
  input  wire smc_reg_req_t              reg_req_in,
  output logic [SMC_DATA_W-1:0]          reg_rdata_out,
  output logic                           reg_rvalid_out,
  // scanning datapath side
  input  wire logic                      poll_start_in,
  input  wire smc_sample_t               sample_in,
  output smc_size_t                      matrix_size_out,
  output logic                           matrix_enabled_out,
  output logic [2:0]                     matrix_poll_active_time_out,
  output logic                           matrix_poll_active_out,
  output logic                           matrix_poll_done_out,
  output logic [SMC_THRESH_W-1:0]        common_threshold_value_out,
  output smc_edge_t                      common_threshold_irq_edges_out,
  output logic [SMC_NUM_INPUTS-1:0]      input_adc_select_out,
  output logic [SMC_NUM_INPUTS-1:0]      input_comparator_select_out,
  output logic                           common_threshold_above_out,
  output logic                           common_threshold_event_out
);

  typedef struct packed {
    smc_matrix_cfg_t           matrix_scan_config;
    logic [SMC_DATA_W-1:0]     input_detect_mode;
    logic [SMC_DATA_W-1:0]     rdata;
    logic                      rvalid;
    logic                      have_ref;
    logic                      above;
    logic                      evt;
  } smc_state_t;

  smc_state_t st_ff;
  smc_state_t nxt_st;

  logic       timer_active;
  logic       timer_done;

  ////////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // only two offsets live here, everything else reads zero and drops writes
  function automatic logic addr_known(input logic [SMC_ADDR_W-1:0] addr);
    addr_known = (addr == SMC_OFS_MATRIX) || (addr == SMC_OFS_MODE);
  endfunction

  // field by field so a change of field layout cannot leak into reserved bits
  function automatic smc_matrix_cfg_t unpack_matrix(input logic [SMC_DATA_W-1:0] w);
    smc_matrix_cfg_t c;
    c           = '0;
    c.rsvd      = '0;
    c.irq_edges = smc_edge_t'(w[SMC_POS_EDGES +: 2]);
    c.thresh    = w[SMC_POS_THRESH +: SMC_THRESH_W];
    c.size      = smc_size_t'(w[SMC_POS_SIZE +: 2]);
    c.act_time  = w[SMC_POS_ACT +: 3];
    unpack_matrix = c;
  endfunction

  function automatic logic [SMC_DATA_W-1:0] read_mux(input logic [SMC_ADDR_W-1:0] addr,
                                                     input smc_state_t s);
    case (addr)
      SMC_OFS_MATRIX: read_mux = s.matrix_scan_config & SMC_MATRIX_MASK;
      SMC_OFS_MODE:   read_mux = s.input_detect_mode;
      default:        read_mux = '0;
    endcase
  endfunction

  function automatic logic edge_fires(input smc_edge_t sel,
                                      input logic      was_above,
                                      input logic      now_above);
    logic rise;
    logic fall;
    rise = !was_above && now_above;
    fall = was_above && !now_above;
    case (sel)
      SMC_EDGE_OFF:  edge_fires = 1'b0;
      SMC_EDGE_RISE: edge_fires = rise;
      SMC_EDGE_FALL: edge_fires = fall;
      SMC_EDGE_BOTH: edge_fires = rise | fall;
      default:       edge_fires = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic now_above;
    now_above = 1'b0;
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.evt    = 1'b0;

    if (reg_req_in.wr_en && addr_known(reg_req_in.addr)) begin
      case (reg_req_in.addr)
        SMC_OFS_MATRIX: begin
          // reserved bits cannot be set by any write
          nxt_st.matrix_scan_config = unpack_matrix(reg_req_in.wdata);
        end
        SMC_OFS_MODE: begin
          nxt_st.input_detect_mode = reg_req_in.wdata;
        end
        default: begin
          nxt_st.rvalid = 1'b0;
        end
      endcase
    end

    if (reg_req_in.rd_en) begin
      // unknown offsets answer zero but still pulse valid so the host never stalls
      nxt_st.rdata  = addr_known(reg_req_in.addr) ? read_mux(reg_req_in.addr, st_ff) : '0;
      nxt_st.rvalid = 1'b1;
    end

    // crossing compare: strictly above counts as above
    if (sample_in.valid) begin
      now_above       = sample_in.value > st_ff.matrix_scan_config.thresh;
      nxt_st.above    = now_above;
      nxt_st.have_ref = 1'b1;
      // first sample only establishes a reference, no crossing yet
      if (st_ff.have_ref) begin
        nxt_st.evt = edge_fires(st_ff.matrix_scan_config.irq_edges,
                                st_ff.above, now_above);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '{matrix_scan_config: SMC_RST_MATRIX,
                 input_detect_mode:  SMC_RST_MODE,
                 rdata:              '0,
                 rvalid:             1'b0,
                 have_ref:           1'b0,
                 above:              1'b0,
                 evt:                1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // matrix poll active window; polls only start with a matrix selected

  smc_poll_timer #(
    .CYCLES_PER_US (CYCLES_PER_US)
  ) u_poll_timer (
    .clock_in    (clock_in),
    .rst_b_in    (rst_b_in),
    .start_in    (poll_start_in && matrix_enabled_out),
    .act_code_in (st_ff.matrix_scan_config.act_time),
    .active_out  (timer_active),
    .done_out    (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // per-input detection select

  genvar gi;
  generate
    for (gi = 0; gi < SMC_NUM_INPUTS; gi++) begin : g_input
      assign input_adc_select_out[gi]        = st_ff.input_detect_mode[gi];
      assign input_comparator_select_out[gi] = !st_ff.input_detect_mode[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out                  = st_ff.rdata;
  assign reg_rvalid_out                 = st_ff.rvalid;
  assign matrix_size_out                = st_ff.matrix_scan_config.size;
  // 4x4 relies on host having set polling and matching input setup
  assign matrix_enabled_out             = (st_ff.matrix_scan_config.size != SMC_SIZE_NONE);
  assign matrix_poll_active_time_out    = st_ff.matrix_scan_config.act_time;
  assign matrix_poll_active_out         = timer_active;
  assign matrix_poll_done_out           = timer_done;
  assign common_threshold_value_out     = st_ff.matrix_scan_config.thresh;
  assign common_threshold_irq_edges_out = st_ff.matrix_scan_config.irq_edges;
  assign common_threshold_above_out     = st_ff.above;
  assign common_threshold_event_out     = st_ff.evt;

endmodule

// [smc_pkg.sv]
package smc_pkg;

  localparam int unsigned SMC_DATA_W      = 24;
  localparam int unsigned SMC_ADDR_W      = 6;
  localparam int unsigned SMC_NUM_INPUTS  = 24;
  localparam int unsigned SMC_THRESH_W    = 10;

  localparam logic [5:0]  SMC_OFS_MATRIX  = 6'h31;
  localparam logic [5:0]  SMC_OFS_MODE    = 6'h32;
  localparam logic [23:0] SMC_RST_MATRIX  = 24'h000000;
  localparam logic [23:0] SMC_RST_MODE    = 24'h000000;
  localparam logic [23:0] SMC_MATRIX_MASK = 24'h01ffff;

  localparam int unsigned SMC_POS_ACT     = 0;
  localparam int unsigned SMC_POS_SIZE    = 3;
  localparam int unsigned SMC_POS_THRESH  = 5;
  localparam int unsigned SMC_POS_EDGES   = 15;
  localparam int unsigned SMC_POS_RSVD    = 17;

  // clock period and derived cycles per microsecond
  localparam int unsigned SMC_CLK_PERIOD_NS  = 25;
  localparam int unsigned SMC_NS_PER_US      = 1000;
  localparam int unsigned SMC_CYCLES_PER_US  = SMC_NS_PER_US / SMC_CLK_PERIOD_NS;
  localparam int unsigned SMC_ACT_CNT_W      = 20;

  localparam int unsigned SMC_ACT_US [8] = '{64, 128, 256, 384, 512, 768, 1024, 1360};

  typedef enum logic [1:0] {
    SMC_SIZE_NONE = 2'b00,
    SMC_SIZE_4X4  = 2'b01,
    SMC_SIZE_5X5  = 2'b10,
    SMC_SIZE_6X6  = 2'b11
  } smc_size_t;

  typedef enum logic [1:0] {
    SMC_EDGE_OFF  = 2'b00,
    SMC_EDGE_RISE = 2'b01,
    SMC_EDGE_FALL = 2'b10,
    SMC_EDGE_BOTH = 2'b11
  } smc_edge_t;

  typedef enum logic [0:0] {
    SMC_TMR_IDLE   = 1'b0,
    SMC_TMR_ACTIVE = 1'b1
  } smc_tmr_state_t;

  typedef struct packed {
    logic [6:0]              rsvd;
    smc_edge_t               irq_edges;
    logic [SMC_THRESH_W-1:0] thresh;
    smc_size_t               size;
    logic [2:0]              act_time;
  } smc_matrix_cfg_t;

  typedef struct packed {
    logic                    wr_en;
    logic                    rd_en;
    logic [SMC_ADDR_W-1:0]   addr;
    logic [SMC_DATA_W-1:0]   wdata;
  } smc_reg_req_t;

  typedef struct packed {
    logic                    valid;
    logic [SMC_THRESH_W-1:0] value;
  } smc_sample_t;

endpackage

// [smc_poll_timer.sv]
`timescale 1ns/1ps
module smc_poll_timer
  import smc_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = SMC_CYCLES_PER_US
) (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic       start_in,
  input  wire logic [2:0] act_code_in,
  output logic            active_out,
  output logic            done_out
);

  typedef struct packed {
    smc_tmr_state_t           state;
    logic [SMC_ACT_CNT_W-1:0] cnt;
    logic                     done;
  } smc_tmr_reg_t;

  smc_tmr_reg_t st_ff;
  smc_tmr_reg_t nxt_st;

  function automatic logic [SMC_ACT_CNT_W-1:0] act_cycles(input logic [2:0] code);
    act_cycles = SMC_ACT_CNT_W'(SMC_ACT_US[code] * CYCLES_PER_US);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.state)
      SMC_TMR_IDLE: begin
        // code sampled at start so a rewrite mid-poll cannot shorten it
        if (start_in) begin
          nxt_st.state = SMC_TMR_ACTIVE;
          nxt_st.cnt   = act_cycles(act_code_in) - SMC_ACT_CNT_W'(1);
        end
      end
      SMC_TMR_ACTIVE: begin
        if (st_ff.cnt == '0) begin
          nxt_st.state = SMC_TMR_IDLE;
          nxt_st.done  = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - SMC_ACT_CNT_W'(1);
        end
      end
      default: begin
        nxt_st.state = SMC_TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '{state: SMC_TMR_IDLE, cnt: '0, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign active_out = (st_ff.state == SMC_TMR_ACTIVE);
  assign done_out   = st_ff.done;

endmodule

// [smc_checker.sv]
`timescale 1ns/1ps
module smc_checker
  import smc_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = SMC_CYCLES_PER_US
) (
  input logic                      clock_in,
  input logic                      rst_b_in,
  input smc_reg_req_t              reg_req_in,
  input logic [SMC_DATA_W-1:0]     reg_rdata_out,
  input logic                      reg_rvalid_out,
  input smc_sample_t               sample_in,
  input smc_size_t                 matrix_size_out,
  input logic                      matrix_enabled_out,
  input logic [2:0]                matrix_poll_active_time_out,
  input logic                      matrix_poll_active_out,
  input logic                      matrix_poll_done_out,
  input logic [SMC_THRESH_W-1:0]   common_threshold_value_out,
  input smc_edge_t                 common_threshold_irq_edges_out,
  input logic [SMC_NUM_INPUTS-1:0] input_adc_select_out,
  input logic [SMC_NUM_INPUTS-1:0] input_comparator_select_out,
  input logic                      common_threshold_above_out,
  input logic                      common_threshold_event_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  // window length in cycles; code held from the cycle before the window
  logic [19:0] cnt_ff;
  logic [2:0]  code_ff;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff  <= '0;
      code_ff <= '0;
    end else begin
      cnt_ff  <= matrix_poll_active_out ? cnt_ff + 20'h00001 : 20'h00000;
      code_ff <= matrix_poll_active_out ? code_ff : matrix_poll_active_time_out;
    end
  end
  AST_EVT_EDGE: assert property (
    common_threshold_event_out |-> (common_threshold_above_out ?
    $past(common_threshold_irq_edges_out[0]) : $past(common_threshold_irq_edges_out[1])))
    else $error("event not enabled by edge field");
  AST_ABOVE: assert property ($past(sample_in.valid) |->
    common_threshold_above_out == ($past(sample_in.value) > $past(common_threshold_value_out)))
    else $error("above flag wrong");
  AST_SIZE_EN: assert property (
    matrix_enabled_out == (matrix_size_out != SMC_SIZE_NONE))
    else $error("matrix enable wrong");
  AST_POLL_LEN: assert property ($fell(matrix_poll_active_out) |->
    matrix_poll_done_out && cnt_ff == SMC_ACT_US[code_ff] * CYCLES_PER_US)
    else $error("poll window length wrong");
  AST_MODE_WR: assert property (
    reg_req_in.wr_en && reg_req_in.addr == SMC_OFS_MODE |=> input_adc_select_out ==
    $past(reg_req_in.wdata) && input_comparator_select_out == ~input_adc_select_out)
    else $error("mode write wrong");
  AST_CFG_WR: assert property (
    reg_req_in.wr_en && reg_req_in.addr == SMC_OFS_MATRIX |=> {common_threshold_irq_edges_out,
    common_threshold_value_out, matrix_size_out, matrix_poll_active_time_out} ==
    $past(reg_req_in.wdata[16:0])) else $error("config write wrong");
  AST_RD_LAT: assert property (reg_req_in.rd_en |=> reg_rvalid_out)
    else $error("read answer missing");
  AST_RSVD: assert property (
    reg_rvalid_out && $past(reg_req_in.addr) == SMC_OFS_MATRIX |-> reg_rdata_out[23:17] == 7'h00)
    else $error("reserved bits not zero");
  AST_RD_MODE: assert property (
    reg_rvalid_out && $past(reg_req_in.addr) == SMC_OFS_MODE |->
    reg_rdata_out == $past(input_adc_select_out)) else $error("mode read wrong");
endmodule
bind smc_matrix_cfg smc_checker #(.CYCLES_PER_US(CYCLES_PER_US)) i_chk (.*);

// [smc_host_model.sv]
`timescale 1ns/1ps
module smc_host_model
  import smc_pkg::*;
(
  input  logic                  clock_in,
  input  logic [SMC_DATA_W-1:0] rdata_in,
  output smc_reg_req_t          req_out
);
  initial req_out = '0;
  // idle address and data inverted so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clock_in);
    #1;
    req_out = '{1'b1, 1'b0, a, d};
    @(posedge clock_in);
    #1;
    req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clock_in);
    #1;
    req_out = '{1'b0, 1'b1, a, ~req_out.wdata};
    @(posedge clock_in);
    #1;
    req_out = '{1'b0, 1'b0, ~a, req_out.wdata};
    d = rdata_in;
  endtask
  // matrix inputs put in comparator mode before scanning is switched on
  task automatic matrix_on(input logic [2:0] c);
    wr(SMC_OFS_MODE, 24'h000000);
    wr(SMC_OFS_MATRIX, {21'h000000, c} | 24'h000008);
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench
  import smc_pkg::*;
;
  localparam int unsigned CPU = 1;
  logic                  clock_in = 1'b0;
  logic                  rst_b_in = 1'b0;
  logic                  poll_start_in = 1'b0;
  smc_sample_t           sample_in = '0;
  smc_reg_req_t          reg_req_in;
  logic [SMC_DATA_W-1:0] reg_rdata_out, input_adc_select_out, input_comparator_select_out;
  logic [9:0]            common_threshold_value_out, t;
  smc_size_t             matrix_size_out;
  smc_edge_t             common_threshold_irq_edges_out;
  logic [2:0]            matrix_poll_active_time_out;
  logic                  reg_rvalid_out, matrix_enabled_out, matrix_poll_active_out;
  logic                  matrix_poll_done_out, common_threshold_above_out;
  logic                  common_threshold_event_out;
  logic [23:0]           d, q;
  int                    n, fail_count = 0, num_checks = 0;
  ////////////////////////////////////////
  smc_host_model i_host (
    .clock_in (clock_in),
    .rdata_in (reg_rdata_out),
    .req_out  (reg_req_in)
  );
  smc_matrix_cfg #(.CYCLES_PER_US(CPU)) i_smc_matrix_cfg (.*);
  initial forever #12.5 clock_in = ~clock_in;
  function automatic logic [23:0] cfg_exp(input logic [23:0] v);
    return v & 24'h01ffff;
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic samp(input logic [9:0] v, input logic ev, input logic ab);
    @(posedge clock_in);
    #1;
    sample_in = '{1'b1, v};
    @(posedge clock_in);
    #1;
    sample_in = '{1'b0, ~v};
    chk(24'(common_threshold_event_out), 24'(ev));
    chk(24'(common_threshold_above_out), 24'(ab));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(52));
    repeat (20) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    i_host.rd(SMC_OFS_MATRIX, q);
    chk(q, 24'h000000);
    i_host.rd(SMC_OFS_MODE, q);
    chk(q, 24'h000000);
    chk(input_comparator_select_out, 24'hffffff);
    $display("test reset finished");
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 24'hffffff : 24'($urandom);
      i_host.wr(SMC_OFS_MATRIX, d);
      chk(24'({common_threshold_irq_edges_out, common_threshold_value_out, matrix_size_out,
          matrix_poll_active_time_out}), cfg_exp(d));
      i_host.rd(SMC_OFS_MATRIX, q);
      chk(q, cfg_exp(d));
      i_host.wr(SMC_OFS_MODE, d);
      i_host.rd(SMC_OFS_MODE, q);
      chk(q, d);
      chk(input_comparator_select_out, ~d);
      i_host.wr(i[0] ? 6'h33 : 6'h30, ~d);
      i_host.rd(i[0] ? 6'h33 : 6'h30, q);
      chk(q, 24'h000000);
    end
    $display("test registers finished");
    // a start with scanning off must be ignored
    for (int c = -1; c < 8; c++) begin
      if (c < 0) i_host.wr(SMC_OFS_MATRIX, 24'h000000);
      else i_host.matrix_on(3'(c));
      n = 0;
      poll_start_in = 1'b1;
      @(posedge clock_in);
      #1;
      poll_start_in = 1'b0;
      while (matrix_poll_active_out === 1'b1 && n < 2000) begin
        @(posedge clock_in);
        #1;
        n++;
      end
      chk(24'(n), c < 0 ? 24'h000000 : 24'(SMC_ACT_US[c] * CPU));
      if (c >= 0) chk(24'(matrix_poll_done_out), 24'h000001);
    end
    $display("test poll finished");
    for (int e = 0; e < 4; e++) begin
      t = 10'($urandom_range(1022, 1));
      i_host.wr(SMC_OFS_MATRIX, {7'h00, 2'(e), t, 5'h00});
      samp(t, 1'b0, 1'b0);
      samp(t + 10'h001, e[0], 1'b1);
      samp(t, e[1], 1'b0);
    end
    $display("test edges finished");
    // reset in mid-run must bring the configuration back to zero
    i_host.wr(SMC_OFS_MATRIX, 24'h01ffff);
    @(posedge clock_in);
    #1;
    rst_b_in = 1'b0;
    @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    chk(24'(matrix_size_out), 24'h000000);
    i_host.rd(SMC_OFS_MATRIX, q);
    chk(q, 24'h000000);
    $display("test midreset finished");
    conclude();
  end
  // whole run needs under 6000 cycles
  initial begin
    #(25 * 20000);
    fail_count++;
    conclude();
  end
endmodule
